// file: apoc_pkg.sv
// package: constants for the parallel output control block
package apoc_pkg;
  // ==========================================================================
  // data widths and codes
  localparam int          SAMPLE_W       = 14;
  localparam logic [13:0] CODE_OB_MAX    = 14'h3FFF;
  localparam logic [13:0] CODE_OB_MIN    = 14'h0000;
  localparam logic [13:0] CODE_OB_ZERO   = 14'h2000;
  localparam int          SIGN_BIT       = 13;
  // ==========================================================================
  // format strap levels (two-bit quantised strap)
  localparam logic [1:0]  STRAP_GND      = 2'h0;
  localparam logic [1:0]  STRAP_THIRD    = 2'h1;
  localparam logic [1:0]  STRAP_TWO_THD  = 2'h2;
  localparam logic [1:0]  STRAP_VDD      = 2'h3;
  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          NAP_WAKE_CYC   = 100;
  localparam int          LOCK_CYC       = 100;
  localparam int          SLEEP_WAKE_US  = 2000;
  localparam int          SLEEP_WAKE_CYC = (SLEEP_WAKE_US * 1000) / CLK_PERIOD_NS;
  localparam int          PIPE_LAT       = 5;
  // ==========================================================================
  // register map
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_IRQ        = 4'h8;
  localparam logic [3:0]  REG_MASK       = 4'hC;
  localparam int          CTRL_PD        = 0;
  localparam int          CTRL_OE_N      = 1;
  localparam int          IRQ_OVR        = 0;
  localparam int          IRQ_VALID      = 1;
  localparam logic [1:0]  RESP_OK        = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  // ==========================================================================
  // operating modes
  typedef enum logic [1:0] {APOC_RUN, APOC_NAP, APOC_SLEEP, APOC_WAKE} apoc_mode_t;
endpackage : apoc_pkg

// file: apoc_delay_line.sv
// module: fixed-latency register pipeline for code plus flag
module apoc_delay_line #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 5
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [DEPTH];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage[i] <= '0;
    end
    else if (ce)
    begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++)
        stage[i] <= stage[i-1];
    end
  end

  assign dout = stage[DEPTH-1];
endmodule : apoc_delay_line

// file: apoc_output_ctrl.sv
// module: digital output stage of a 14-bit sampling converter
// Overview of operation
// - offset binary: full scale ones, zero 0x2000
// - two's complement inverts offset binary msb
// - overrange raises flag, clamps code to extreme
// - four-level strap picks format and stabilizer
// - output enable high tristates data and flag
// - power down low gives normal conversion
// - power down with enable high sleeps, slow wake
// - power down with enable low naps unless already asleep, 100-cycle wake
// - sleep and nap tristate the data and flag outputs
// - stabilizer samples rising edge, 50% duty
// - stabilizer needs 100 cycles to relock
module apoc_output_ctrl #(
  parameter int SLEEP_WAKE = apoc_pkg::SLEEP_WAKE_CYC,
  parameter int LATENCY    = apoc_pkg::PIPE_LAT
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // converter core input
  input  wire logic [14:0] raw_sample,
  input  wire logic [1:0]  format_strap,
  input  wire logic        clock_stopped,
  // parallel output pins
  output logic      [13:0] sample_code_bits,
  output logic      [13:0] sample_code_bits_oe,
  output logic             overrange_flag,
  output logic             overrange_flag_oe,
  output logic             data_valid,
  output logic             stabilizer_on,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq
);
  // ==========================================================================
  // encoding
  // raw_sample is a signed 15-bit level; beyond the 14-bit span is overrange
  function automatic logic [14:0] apoc_encode(input logic [14:0] raw, input logic twos);
    logic signed [14:0] v;
    logic [13:0]        ob;
    logic               ovr;
    v   = raw;
    ovr = 1'b0;
    if (v > 15'sh1FFF)
    begin
      ob  = apoc_pkg::CODE_OB_MAX;
      ovr = 1'b1;
    end
    else if (v < -15'sh2000)
    begin
      ob  = apoc_pkg::CODE_OB_MIN;
      ovr = 1'b1;
    end
    else
      ob = 14'(v) ^ apoc_pkg::CODE_OB_ZERO;
    if (twos)
      ob[apoc_pkg::SIGN_BIT] = ~ob[apoc_pkg::SIGN_BIT];
    return {ovr, ob};
  endfunction : apoc_encode

  logic        strap_twos;
  logic [14:0] coded;
  logic [14:0] piped;
  assign strap_twos    = (format_strap == apoc_pkg::STRAP_TWO_THD) || (format_strap == apoc_pkg::STRAP_VDD);
  assign stabilizer_on = (format_strap == apoc_pkg::STRAP_THIRD) || (format_strap == apoc_pkg::STRAP_TWO_THD);
  assign coded         = apoc_encode(raw_sample, strap_twos);

  apoc_delay_line #(.WIDTH(15), .DEPTH(LATENCY)) u_pipe (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (coded),
    .dout    (piped)
  );

  // ==========================================================================
  // control register and power modes
  logic                  ctrl_pd;
  logic                  ctrl_oe_n;
  apoc_pkg::apoc_mode_t  mode;
  apoc_pkg::apoc_mode_t  next_mode;
  logic [31:0]           wake_cnt;
  logic [31:0]           next_wake_cnt;
  logic                  lock_busy;
  logic [7:0]            lock_cnt;
  logic                  valid_rise;
  logic                  prev_valid;

  always_comb
  begin
    next_mode     = mode;
    next_wake_cnt = (wake_cnt != 0) ? wake_cnt - 32'h1 : 32'h0;
    unique case (mode)
      apoc_pkg::APOC_RUN:
        if (ctrl_pd)
          next_mode = ctrl_oe_n ? apoc_pkg::APOC_SLEEP : apoc_pkg::APOC_NAP;
      apoc_pkg::APOC_NAP, apoc_pkg::APOC_SLEEP:
        if (!ctrl_pd)
        begin
          next_mode     = apoc_pkg::APOC_WAKE;
          // a nap keeps the reference up, so recovery is short
          next_wake_cnt = (mode == apoc_pkg::APOC_NAP) ? 32'(apoc_pkg::NAP_WAKE_CYC) : 32'(SLEEP_WAKE);
        end
        else if (mode == apoc_pkg::APOC_NAP && ctrl_oe_n)
          next_mode = apoc_pkg::APOC_SLEEP;
      apoc_pkg::APOC_WAKE:
        if (ctrl_pd)
          next_mode = ctrl_oe_n ? apoc_pkg::APOC_SLEEP : apoc_pkg::APOC_NAP;
        else if (wake_cnt <= 32'h1)
          next_mode = apoc_pkg::APOC_RUN;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode     <= apoc_pkg::APOC_RUN;
      wake_cnt <= 32'h0;
    end
    else if (ce)
    begin
      mode     <= next_mode;
      wake_cnt <= next_wake_cnt;
    end
  end

  // stabilizer relock after a stopped clock; the stop is reported by the clock monitor
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_cnt <= 8'h0;
    else if (ce)
    begin
      if (clock_stopped && stabilizer_on)
        lock_cnt <= 8'(apoc_pkg::LOCK_CYC);
      else if (lock_cnt != 8'h0)
        lock_cnt <= lock_cnt - 8'h1;
    end
  end
  assign lock_busy = (lock_cnt != 8'h0);

  // ==========================================================================
  // output pins
  logic drive;
  assign drive = !ctrl_oe_n && (mode == apoc_pkg::APOC_RUN || mode == apoc_pkg::APOC_WAKE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_code_bits <= 14'h0000;
      overrange_flag   <= 1'b0;
      data_valid       <= 1'b0;
    end
    else if (ce)
    begin
      sample_code_bits <= piped[13:0];
      overrange_flag   <= piped[14];
      data_valid       <= (next_mode == apoc_pkg::APOC_RUN) && !lock_busy;
    end
  end
  assign sample_code_bits_oe = {14{drive}};
  assign overrange_flag_oe   = drive;

  // ==========================================================================
  // axi4-lite slave: one write and one read in flight
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        do_write;
  logic        rd_take;
  logic        wr_ctrl;
  logic        wr_mask;
  logic        wr_hit;
  logic        rd_hit;
  logic        rd_stat_clr;
  logic [31:0] rd_mux;
  logic [1:0]  irq_set;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl       = do_write && aw_addr == apoc_pkg::REG_CTRL && w_strb[0];
  assign wr_mask       = do_write && aw_addr == apoc_pkg::REG_MASK && w_strb[0];
  assign wr_hit        = aw_addr == apoc_pkg::REG_CTRL || aw_addr == apoc_pkg::REG_MASK;
  assign rd_hit        = s_axi_araddr == apoc_pkg::REG_CTRL || s_axi_araddr == apoc_pkg::REG_STATUS ||
                         s_axi_araddr == apoc_pkg::REG_IRQ || s_axi_araddr == apoc_pkg::REG_MASK;
  assign rd_stat_clr   = rd_take && s_axi_araddr == apoc_pkg::REG_IRQ;
  assign valid_rise    = data_valid && !prev_valid;
  assign irq_set       = {valid_rise, overrange_flag && data_valid};
  assign rd_mux        = (s_axi_araddr == apoc_pkg::REG_CTRL)   ? {30'h0, ctrl_oe_n, ctrl_pd} :
                         (s_axi_araddr == apoc_pkg::REG_STATUS) ? {26'h0, lock_busy, stabilizer_on,
                                                                   strap_twos, data_valid, mode} :
                         (s_axi_araddr == apoc_pkg::REG_IRQ)    ? {30'h0, irq_stat} :
                         (s_axi_araddr == apoc_pkg::REG_MASK)   ? {30'h0, irq_mask} : 32'h0;
  assign irq           = |(irq_stat & irq_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= apoc_pkg::RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= apoc_pkg::RESP_OK;
      s_axi_rdata  <= 32'h0;
      ctrl_pd      <= 1'b0;
      ctrl_oe_n    <= 1'b0;
      irq_mask     <= 2'h0;
      irq_stat     <= 2'h0;
      prev_valid   <= 1'b0;
    end
    else if (ce)
    begin
      prev_valid <= data_valid;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? apoc_pkg::RESP_OK : apoc_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
      begin
        ctrl_pd   <= w_data[apoc_pkg::CTRL_PD];
        ctrl_oe_n <= w_data[apoc_pkg::CTRL_OE_N];
      end
      if (wr_mask)
        irq_mask <= w_data[1:0];
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? apoc_pkg::RESP_OK : apoc_pkg::RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // a new event in the clearing cycle survives the read
      irq_stat <= (rd_stat_clr ? 2'h0 : irq_stat) | irq_set;
    end
  end

  // ==========================================================================
  // checks
  a_tristate_when_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_oe_n |-> !overrange_flag_oe && sample_code_bits_oe == 14'h0000)
    else $error("outputs driven while output enable is high");
  a_tristate_power_down: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == apoc_pkg::APOC_NAP || mode == apoc_pkg::APOC_SLEEP) |->
      !overrange_flag_oe && sample_code_bits_oe == 14'h0000)
    else $error("outputs driven in nap or sleep");
  a_enter_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl_pd && ctrl_oe_n && mode == apoc_pkg::APOC_RUN) |=> mode == apoc_pkg::APOC_SLEEP)
    else $error("sleep not entered");
  a_enter_nap: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl_pd && !ctrl_oe_n && mode == apoc_pkg::APOC_RUN) |=> mode == apoc_pkg::APOC_NAP)
    else $error("nap not entered");
  a_nap_wake_time: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && mode == apoc_pkg::APOC_NAP && !ctrl_pd) |=> wake_cnt == 32'(apoc_pkg::NAP_WAKE_CYC))
    else $error("nap recovery count wrong");
  a_overrange_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    coded[14] |-> (coded[12:0] == 13'h1FFF || coded[12:0] == 13'h0000))
    else $error("overrange code not clamped");
  a_zero_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_sample == 15'h0000 && !strap_twos) |-> coded == {1'b0, apoc_pkg::CODE_OB_ZERO})
    else $error("offset binary zero code wrong");
  a_twos_msb: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_sample == 15'h0000 && strap_twos) |-> coded == 15'h0000)
    else $error("two's complement zero code wrong");
  a_strap_stab: assert property (@(posedge aclk) disable iff (!aresetn)
    stabilizer_on == (format_strap[1] ^ format_strap[0]))
    else $error("stabilizer decode wrong");
  a_relock_invalid: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && clock_stopped && stabilizer_on) |=> ##1 !data_valid)
    else $error("data valid during relock");
endmodule : apoc_output_ctrl

// file: apoc_capture_model.sv
// downstream capture latch that receives the parallel sample word and flag
module apoc_capture_model (
  // clock
  input  wire logic        aclk,
  // pins from the converter
  input  wire logic [13:0] code_pins,
  input  wire logic [13:0] code_oe,
  input  wire logic        flag_pin,
  input  wire logic        flag_oe,
  // captured word
  output logic      [14:0] bus_seen,
  output logic      [13:0] captured_code,
  output logic             captured_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] last_seen;
  // ==========================================================================
  // bus resolution
  // undriven bits flip every cycle so a floating bus never looks like data
  assign bus_seen = ({flag_oe, code_oe} & {flag_pin, code_pins}) | (~{flag_oe, code_oe} & ~last_seen);
  // ==========================================================================
  // capture latch
  always_ff @(posedge aclk)
  begin
    last_seen     <= bus_seen;
    captured_code <= bus_seen[13:0];
    captured_flag <= bus_seen[14];
  end
endmodule : apoc_capture_model

// file: tb_adc_parallel_output_control.sv
// self-checking bench for the converter parallel output stage
module tb_adc_parallel_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LAT = 5;
  localparam int SLP = 20;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, clock_stopped = 1'b0;
  logic [14:0] raw_sample = 15'h0000;
  logic [1:0] format_strap = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [13:0] sample_code_bits, sample_code_bits_oe, captured_code;
  logic overrange_flag, overrange_flag_oe, data_valid, stabilizer_on, irq, captured_flag;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] rr;
  int fails = 0, total_checks = 0, cyc = 0;
  always #50 aclk = ~aclk;
  // ==========================================================================
  // instances
  apoc_output_ctrl #(.SLEEP_WAKE(SLP), .LATENCY(LAT)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .raw_sample(raw_sample), .format_strap(format_strap), .clock_stopped(clock_stopped),
    .sample_code_bits(sample_code_bits), .sample_code_bits_oe(sample_code_bits_oe),
    .overrange_flag(overrange_flag), .overrange_flag_oe(overrange_flag_oe), .data_valid(data_valid),
    .stabilizer_on(stabilizer_on), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
  apoc_capture_model u_cap (.aclk(aclk), .code_pins(sample_code_bits), .code_oe(sample_code_bits_oe),
    .flag_pin(overrange_flag), .flag_oe(overrange_flag_oe), .bus_seen(), .captured_code(captured_code),
    .captured_flag(captured_flag));
  // ==========================================================================
  // common tasks
  task automatic conclude;
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, apoc_pkg::RESP_OK, "bresp");
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read
  task automatic wait_valid(input int lim);
    int n;
    n = 0;
    while (data_valid !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    chk(data_valid, 1'b1, "valid resumes");
  endtask : wait_valid
  function automatic logic [13:0] exp_code(input int v, input logic [1:0] s);
    int c;
    c = (v > 8191) ? 8191 : ((v < -8192) ? -8192 : v);
    exp_code = 14'(c + 8192) ^ ((s >= 2'h2) ? 14'h2000 : 14'h0000);
  endfunction : exp_code
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    axi_read(apoc_pkg::REG_CTRL, rd, rr);
    chk(rd, 32'h0, "ctrl reset");
    axi_read(apoc_pkg::REG_MASK, rd, rr);
    chk(rd, 32'h0, "mask reset");
    axi_read(4'h6, rd, rr);
    chk(rr, apoc_pkg::RESP_DECERR, "unmapped");
  endtask : t_regs
  task automatic t_codes;
    int vals[7] = '{8191, 0, -8192, 8192, -8193, 1, -1};
    for (int s = 0; s < 4; s++)
      foreach (vals[i])
      begin
        format_strap <= 2'(s);
        raw_sample   <= 15'(vals[i]);
        repeat (LAT + 4) @(posedge aclk);
        chk(captured_code, exp_code(vals[i], 2'(s)), "code");
        chk(captured_flag, (vals[i] > 8191 || vals[i] < -8192), "flag");
        chk(stabilizer_on, (s == 1 || s == 2), "stabilizer");
        chk(sample_code_bits_oe, 14'h3FFF, "driving");
      end
    format_strap <= 2'h0;
    raw_sample   <= 15'h0000;
  endtask : t_codes
  task automatic t_enable;
    // enable toggled with power down held low, short waits before each check
    axi_write(apoc_pkg::REG_CTRL, 32'h2);
    repeat (4) @(posedge aclk);
    chk({overrange_flag_oe, sample_code_bits_oe}, 15'h0000, "oe off");
    axi_write(apoc_pkg::REG_CTRL, 32'h0);
    repeat (LAT + 4) @(posedge aclk);
    chk({overrange_flag_oe, sample_code_bits_oe}, 15'h7FFF, "oe on");
  endtask : t_enable
  task automatic t_power(input logic [31:0] ctl, input logic [1:0] mode, input int quiet, input int lim);
    axi_write(apoc_pkg::REG_CTRL, ctl);
    repeat (4) @(posedge aclk);
    chk({overrange_flag_oe, sample_code_bits_oe}, 15'h0000, "hi-z in low power");
    axi_read(apoc_pkg::REG_STATUS, rd, rr);
    chk(rd[1:0], mode, "mode");
    axi_write(apoc_pkg::REG_CTRL, 32'h0);
    repeat (quiet) @(posedge aclk);
    chk(data_valid, 1'b0, "still waking");
    wait_valid(lim);
  endtask : t_power
  task automatic t_relock;
    // clear earlier events so the valid-rise check below depends on this relock
    axi_read(apoc_pkg::REG_IRQ, rd, rr);
    format_strap  <= 2'h1;
    clock_stopped <= 1'b1;
    repeat (3) @(posedge aclk);
    clock_stopped <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(data_valid, 1'b0, "relocking");
    axi_read(apoc_pkg::REG_STATUS, rd, rr);
    chk(rd[5:4], 2'h3, "relock status");
    wait_valid(120);
    axi_read(apoc_pkg::REG_IRQ, rd, rr);
    chk(rd[1], 1'b1, "valid rise event");
    format_strap <= 2'h0;
  endtask : t_relock
  task automatic t_freeze;
    // a low clock enable must hold the pipeline and the output word
    raw_sample <= 15'(100);
    repeat (LAT + 4) @(posedge aclk);
    ce         <= 1'b0;
    raw_sample <= 15'(-100);
    repeat (LAT + 4) @(posedge aclk);
    chk(sample_code_bits, exp_code(100, 2'h0), "frozen");
    ce <= 1'b1;
    repeat (LAT + 4) @(posedge aclk);
    chk(captured_code, exp_code(-100, 2'h0), "thawed");
    raw_sample <= 15'h0000;
  endtask : t_freeze
  task automatic t_irq(input logic [31:0] mask);
    axi_write(apoc_pkg::REG_MASK, mask);
    raw_sample <= 15'(9000);
    repeat (LAT + 4) @(posedge aclk);
    raw_sample <= 15'h0000;
    repeat (LAT + 4) @(posedge aclk);
    chk(irq, mask[0], "irq level");
    axi_read(apoc_pkg::REG_IRQ, rd, rr);
    chk(rd[0], 1'b1, "overrange event");
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq cleared");
  endtask : t_irq
  // ==========================================================================
  // main sequence and watchdog
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_codes();
    t_freeze();
    t_enable();
    t_power(32'h1, 2'h1, 80, 60);
    t_power(32'h3, 2'h2, SLP / 2, 160);
    t_relock();
    t_irq(32'h1);
    t_irq(32'h0);
    conclude();
  end
endmodule : tb_adc_parallel_output_control
